// ---- hdl/darc_top.sv ----
// DRAM area control and refresh control: registers, strobe generation,
// address multiplexing, burst row compare and refresh sequencing.
// Assumes one clock, synchronous active-low reset and AXI4-Lite master.
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module darc_top #(
   parameter int ADDR_W = 28
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic dram_space_enable,
   input wire logic refresh_wait_enable,
   input wire logic phase_tick,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic req_write,
   input wire logic req_wide,
   input wire logic req_hi_byte,
   input wire logic req_lo_byte,
   output logic [ADDR_W-1:0] dram_addr,
   output logic ras_n,
   output logic high_column_strobe_n,
   output logic low_column_strobe_n,
   output logic high_write_strobe_n,
   output logic low_write_strobe_n,
   output logic refresh_active
);
   import darc_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [15:0] area_r;
   logic [15:0] refr_r;
   logic [7:0] cmp_r;
   logic [7:0] cnt_r;
   logic cmf_r;
   logic aw_hold_r, w_hold_r;
   logic [3:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   darc_state_e st_r;
   logic [2:0] wcnt_r;
   logic [4:0] ph_r;
   logic [ADDR_W-1:0] row_r, addr_r;
   logic row_ok_r, cbr_pend_r, wr_r, wide_r, hi_r, lo_r, acc_pend_r;

   // Returns the row address bits kept after the selected shift.
   function automatic logic [ADDR_W-1:0] row_of(
      input logic [ADDR_W-1:0] a, input logic [1:0] sel);
      logic [ADDR_W-1:0] r;
      r = '0;
      case (sel)
         2'b00: r = a >> 8;
         2'b01: r = a >> 9;
         2'b10: r = a >> 10;
         default: r = a >> 8;
      endcase
      return r;
   endfunction

   logic area_on;
   logic [1:0] shift_sel;
   logic cbr_mode, self_mode, match, wr_go, row_hit;
   assign area_on = dram_space_enable;
   assign shift_sel = area_r[DARC_B_SHIFT +: 2];
   assign cbr_mode = refr_r[DARC_B_RFEN] & ~refr_r[DARC_B_RKIND];
   assign self_mode = refr_r[DARC_B_RFEN] & refr_r[DARC_B_RKIND];
   assign match = phase_tick && (cnt_r == cmp_r);
   // Reserved shift code compares like code 00 so the state stays sane.
   assign row_hit = area_r[DARC_B_BURST] && row_ok_r &&
      (row_of(req_addr, shift_sel) == row_of(row_r, shift_sel));
   assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

   // ---------------------------------------------------------------
   // AXI4-Lite write side
   // ---------------------------------------------------------------
   // Address and data are latched independently, in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= DARC_RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r[3:2] == DARC_ADDR_STAT[3:2]) ?
               DARC_RESP_ERR : DARC_RESP_OK;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_hold_r;
   assign s_axi_wready = !w_hold_r;

   // Register stores; keyed word write protects refresh control.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         area_r <= DARC_AREA_RST;
         refr_r <= DARC_REFR_RST;
         cmp_r <= DARC_CMP_RST;
      end else if (wr_go) begin
         case (awaddr_r)
            DARC_ADDR_AREA: begin
               if (wstrb_r[1])
                  area_r[15:8] <= wdata_r[15:8];
            end
            DARC_ADDR_REFR: begin
               // Both byte lanes and the key must be present.
               if (wstrb_r[1:0] == 2'b11 &&
                   wdata_r[15:8] == DARC_REFR_KEY)
                  refr_r <= {8'h00, wdata_r[7:0]} & DARC_REFR_MASK;
            end
            DARC_ADDR_CTRL: begin
               if (wstrb_r[0])
                  cmp_r <= wdata_r[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read side
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= DARC_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= DARC_RESP_OK;
         case (s_axi_araddr)
            DARC_ADDR_AREA: s_axi_rdata <= {16'h0000,
               area_r & DARC_AREA_MASK};
            DARC_ADDR_REFR: s_axi_rdata <= {16'h0000,
               refr_r & DARC_REFR_MASK};
            DARC_ADDR_CTRL: s_axi_rdata <= {24'h00_0000, cmp_r};
            DARC_ADDR_STAT: s_axi_rdata <= {16'h0000, cmf_r, 7'h00, cnt_r};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= DARC_RESP_ERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;

   // ---------------------------------------------------------------
   // Refresh timer
   // ---------------------------------------------------------------
   // Counter runs on phase_tick; the flag is sticky, set wins over clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 8'h00;
         cmf_r <= 1'b0;
      end else begin
         if (match)
            cnt_r <= 8'h00;
         else if (phase_tick)
            cnt_r <= cnt_r + 8'h01;
         if (match)
            cmf_r <= 1'b1;
         else if (wr_go && awaddr_r == DARC_ADDR_STAT && wstrb_r[1] &&
                  !wdata_r[15])
            cmf_r <= 1'b0;
      end
   end

   // A match while refresh is off only flags; with CBR it queues a refresh.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         cbr_pend_r <= 1'b0;
      else if (match && cbr_mode)
         cbr_pend_r <= 1'b1;
      else if (st_r == DARC_RCAS)
         cbr_pend_r <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Access and refresh sequencer
   // ---------------------------------------------------------------
   // One state spans DARC_COL_TICKS clocks; ph_r counts within it.
   logic st_end;
   assign st_end = (ph_r == DARC_COL_TICKS - 5'd1);
   assign req_ready = area_on && !self_mode && !cbr_pend_r &&
      ((st_r == DARC_IDLE) || (st_r == DARC_COL && st_end));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= DARC_IDLE;
         ph_r <= 5'd0;
         wcnt_r <= 3'd0;
         acc_pend_r <= 1'b0;
         row_r <= '0;
         addr_r <= '0;
         row_ok_r <= 1'b0;
         {wr_r, wide_r, hi_r, lo_r} <= 4'b0000;
      end else begin
         ph_r <= (st_end || st_r == DARC_IDLE || st_r == DARC_SELF) ?
            5'd0 : ph_r + 5'd1;
         if (req_valid && req_ready) begin
            addr_r <= req_addr;
            {wr_r, wide_r, hi_r, lo_r} <=
               {req_write, req_wide, req_hi_byte, req_lo_byte};
            row_r <= req_addr;
            row_ok_r <= 1'b1;
            ph_r <= 5'd0;
            if (row_hit && st_r == DARC_COL && area_r[DARC_B_RASHOLD])
               st_r <= DARC_COL;
            else if (row_hit && st_r == DARC_IDLE && !ras_n)
               st_r <= DARC_COL;
            else if (!ras_n) begin
               st_r <= DARC_PRE;
               acc_pend_r <= 1'b1;
            end
            else
               st_r <= DARC_ROW;
         end else begin
            case (st_r)
               DARC_IDLE: begin
                  if (cbr_pend_r || self_mode) begin
                     row_ok_r <= 1'b0;
                     st_r <= ras_n ? DARC_RCAS : DARC_PRE;
                  end
               end
               DARC_ROW: if (st_end) st_r <= DARC_COL;
               DARC_COL: begin
                  if (st_end) begin
                     if (!area_r[DARC_B_RASHOLD] || cbr_pend_r ||
                         self_mode || !area_on) begin
                        st_r <= DARC_PRE;
                        row_ok_r <= 1'b0;
                     end else
                        st_r <= DARC_IDLE;
                  end
               end
               DARC_PRE: begin
                  if (st_end) begin
                     if (area_r[DARC_B_TPC] && wcnt_r == 3'd0)
                        wcnt_r <= 3'd1;
                     else begin
                        wcnt_r <= 3'd0;
                        acc_pend_r <= 1'b0;
                        // A request taken with the row open resumes here.
                        if (acc_pend_r)
                           st_r <= DARC_ROW;
                        else
                           st_r <= (cbr_pend_r || self_mode) ?
                              DARC_RCAS : DARC_IDLE;
                     end
                  end
               end
               DARC_RCAS: if (st_end) st_r <= self_mode ? DARC_SELF :
                  DARC_RRAS;
               DARC_RRAS: begin
                  if (st_end) begin
                     // Code n inserts n+1 wait states.
                     if (refresh_wait_enable && wcnt_r !=
                         {1'b0, refr_r[DARC_B_RWAIT +: 2]} + 3'd1)
                        wcnt_r <= wcnt_r + 3'd1;
                     else if (refresh_wait_enable) begin
                        wcnt_r <= 3'd0;
                        st_r <= DARC_PRE;
                     end else
                        st_r <= DARC_PRE;
                  end
               end
               DARC_SELF: if (!self_mode) st_r <= DARC_PRE;
               default: st_r <= DARC_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin outputs
   // ---------------------------------------------------------------
   // Column strobe low phase shaped by duty select; byte enables pick lanes.
   logic cas_lo, col_on, row_phase, ras_hold;
   logic [4:0] hi_len;
   logic [ADDR_W-1:0] mux_addr;
   assign hi_len = area_r[DARC_B_DUTY] ? DARC_HI35 : DARC_HI50;
   assign col_on = (st_r == DARC_COL) && (ph_r >= hi_len);
   assign ras_hold = (st_r == DARC_IDLE) && area_r[DARC_B_RASHOLD] &&
      row_ok_r;
   assign row_phase = (st_r == DARC_ROW);
   assign cas_lo = (st_r == DARC_RCAS) || (st_r == DARC_RRAS) ||
      (st_r == DARC_SELF);
   // Row goes out shifted only when multiplexing is on.
   assign mux_addr = !area_r[DARC_B_MUX] ? addr_r :
      (row_phase ? row_of(addr_r, shift_sel) : addr_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ras_n <= 1'b1;
         high_column_strobe_n <= 1'b1;
         low_column_strobe_n <= 1'b1;
         high_write_strobe_n <= 1'b1;
         low_write_strobe_n <= 1'b1;
         dram_addr <= '0;
         refresh_active <= 1'b0;
      end else begin
         ras_n <= !(row_phase || st_r == DARC_COL || ras_hold ||
            st_r == DARC_RRAS || st_r == DARC_SELF);
         low_column_strobe_n <= !(cas_lo || (col_on && (lo_r || !wide_r)));
         // Dual column scheme uses the high strobe on wide accesses.
         high_column_strobe_n <= !(cas_lo || (col_on && wide_r && hi_r &&
            !area_r[DARC_B_SCHEME]));
         low_write_strobe_n <= !((st_r == DARC_COL) && wr_r &&
            (area_r[DARC_B_SCHEME] && wide_r ? lo_r : 1'b1));
         high_write_strobe_n <= !((st_r == DARC_COL) && wr_r && wide_r &&
            hi_r && area_r[DARC_B_SCHEME]);
         dram_addr <= mux_addr;
         refresh_active <= cas_lo;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_key;
      @(posedge aclk) disable iff (!aresetn)
      (wr_go && awaddr_r == DARC_ADDR_REFR &&
       wdata_r[15:8] != DARC_REFR_KEY) |=> $stable(refr_r);
   endproperty
   a_key: assert property (p_key) else $error("keyless write took");
   property p_match;
      @(posedge aclk) disable iff (!aresetn)
      match |=> (cnt_r == 8'h00) && cmf_r;
   endproperty
   a_match: assert property (p_match) else $error("match lost");
   property p_lowbyte;
      @(posedge aclk) disable iff (!aresetn)
      area_r[7:0] == 8'h00 && refr_r[15:8] == 8'h00 && refr_r[3:0] == 4'h0;
   endproperty
   a_lowbyte: assert property (p_lowbyte) else $error("reserved set");
   property p_8bit;
      @(posedge aclk) disable iff (!aresetn)
      (st_r == DARC_COL && !wide_r) |=> high_write_strobe_n &&
         (high_column_strobe_n || refresh_active);
   endproperty
   a_8bit: assert property (p_8bit) else $error("high strobe on 8-bit");
   property p_off;
      @(posedge aclk) disable iff (!aresetn)
      !area_on |-> !req_ready;
   endproperty
   a_off: assert property (p_off) else $error("access while off");
   property p_nocbr;
      @(posedge aclk) disable iff (!aresetn)
      (match && !refr_r[DARC_B_RFEN] && !cbr_pend_r) |=> !cbr_pend_r;
   endproperty
   a_nocbr: assert property (p_nocbr) else $error("refresh while off");
   property p_pre1;
      @(posedge aclk) disable iff (!aresetn)
      ($rose(st_r == DARC_PRE) && !area_r[DARC_B_TPC] && !self_mode)
         |-> ##20 (st_r != DARC_PRE);
   endproperty
   a_pre1: assert property (p_pre1) else $error("precharge length");
   property p_inval;
      @(posedge aclk) disable iff (!aresetn)
      (st_r == DARC_RCAS) |-> !row_ok_r;
   endproperty
   a_inval: assert property (p_inval) else $error("row kept");
endmodule

// ---- hdl/darc_pkg.sv ----
// Package for the DRAM area and refresh control block.
// Assumes a single 40 MHz clock and an AXI4-Lite register port.
package darc_pkg;
   // ---------------------------------------------------------------
   // Register map and layout
   // ---------------------------------------------------------------
   localparam logic [3:0] DARC_ADDR_AREA = 4'h0;
   localparam logic [3:0] DARC_ADDR_REFR = 4'h4;
   localparam logic [3:0] DARC_ADDR_CTRL = 4'h8;
   localparam logic [3:0] DARC_ADDR_STAT = 4'hC;
   localparam logic [15:0] DARC_AREA_RST = 16'h0000;
   localparam logic [15:0] DARC_REFR_RST = 16'h0000;
   localparam logic [7:0] DARC_REFR_KEY = 8'h5A;
   localparam logic [7:0] DARC_CMP_RST = 8'hFF;
   localparam int DARC_B_SCHEME = 15;
   localparam int DARC_B_RASHOLD = 14;
   localparam int DARC_B_TPC = 13;
   localparam int DARC_B_BURST = 12;
   localparam int DARC_B_DUTY = 11;
   localparam int DARC_B_MUX = 10;
   localparam int DARC_B_SHIFT = 8;
   localparam int DARC_B_RFEN = 7;
   localparam int DARC_B_RKIND = 6;
   localparam int DARC_B_RWAIT = 4;
   localparam logic [15:0] DARC_AREA_MASK = 16'hFF00;
   localparam logic [15:0] DARC_REFR_MASK = 16'h00F0;
   localparam logic [1:0] DARC_RESP_OK = 2'b00;
   localparam logic [1:0] DARC_RESP_ERR = 2'b10;
   // Column state is split into 20 phase ticks for duty shaping.
   localparam logic [4:0] DARC_COL_TICKS = 5'd20;
   localparam logic [4:0] DARC_HI50 = 5'd10;
   localparam logic [4:0] DARC_HI35 = 5'd7;
   typedef enum logic [6:0] {
      DARC_IDLE = 7'b000_0001,
      DARC_ROW = 7'b000_0010,
      DARC_COL = 7'b000_0100,
      DARC_PRE = 7'b000_1000,
      DARC_RCAS = 7'b001_0000,
      DARC_RRAS = 7'b010_0000,
      DARC_SELF = 7'b100_0000
   } darc_state_e;
endpackage

// ---- testbench/darc_dram_model.sv ----
// Behavioural model of the DRAM chips on the memory bus.
// Assumes registered, active-low strobes from the controller.
`timescale 1ns/1ps
module darc_dram_model #(
   parameter int ADDR_W = 28
) (
   input wire logic clk,
   input wire logic clr,
   input wire logic [ADDR_W-1:0] dram_addr,
   input wire logic ras_n,
   input wire logic high_column_strobe_n,
   input wire logic low_column_strobe_n,
   input wire logic high_write_strobe_n,
   input wire logic low_write_strobe_n,
   output int row_opens,
   output int cbr_count,
   output logic [ADDR_W-1:0] row_seen,
   output logic [3:0] low_seen
);
   logic ras_q = 1'b1;
   // ----------------------------------------------------------------
   // Row latch and refresh detection
   // ----------------------------------------------------------------
   // A chip only learns a row on a falling row strobe, so page cycles
   // are invisible here; a column strobe already low means a refresh.
   initial begin
      row_opens = 0;
      cbr_count = 0;
      low_seen = 4'h0;
      row_seen = '0;
   end
   always @(posedge clk) begin
      ras_q <= ras_n;
      if (ras_q && !ras_n) begin
         if (!low_column_strobe_n || !high_column_strobe_n) begin
            cbr_count <= cbr_count + 1;
         end else begin
            row_opens <= row_opens + 1;
            row_seen <= dram_addr;
         end
      end
      // Strobe activity since the last clear, order {hcas,lcas,hwe,lwe}.
      low_seen <= clr ? 4'h0 : low_seen | ~{high_column_strobe_n,
         low_column_strobe_n, high_write_strobe_n, low_write_strobe_n};
   end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the DRAM area and refresh control block.
// Assumes the darc_top ports and the darc_pkg register offsets.
`timescale 1ns/1ps
module tb_top;
   import darc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000, rdata, rd;
   logic [1:0] bresp, rresp, br, rr;
   logic awready, wready, bvalid, arready, rvalid;
   logic dram_en = 1'b1, rwe = 1'b0, tick = 1'b1, clr = 1'b0;
   logic req_valid = 1'b0, req_wide = 1'b1, req_hi = 1'b1, req_ready;
   logic [27:0] req_addr = 28'h000_0000, dram_addr, row_seen;
   logic ras_n, hcas_n, lcas_n, hwe_n, lwe_n, refresh_active;
   logic [3:0] low_seen;
   int row_opens, cbr_count, fails = 0, compares = 0, d0, dk, n0;
   // ----------------------------------------------------------------
   // Clock, design and DRAM model
   // ----------------------------------------------------------------
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   darc_top #(.ADDR_W(28)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .dram_space_enable(dram_en), .refresh_wait_enable(rwe),
      .phase_tick(tick), .req_valid(req_valid), .req_ready(req_ready),
      .req_addr(req_addr), .req_write(1'b1), .req_wide(req_wide),
      .req_hi_byte(req_hi), .req_lo_byte(1'b1), .dram_addr(dram_addr),
      .ras_n(ras_n), .high_column_strobe_n(hcas_n),
      .low_column_strobe_n(lcas_n), .high_write_strobe_n(hwe_n),
      .low_write_strobe_n(lwe_n), .refresh_active(refresh_active));
   darc_dram_model #(.ADDR_W(28)) mem (.clk(aclk), .clr(clr),
      .dram_addr(dram_addr), .ras_n(ras_n), .high_column_strobe_n(hcas_n),
      .low_column_strobe_n(lcas_n), .high_write_strobe_n(hwe_n),
      .low_write_strobe_n(lwe_n), .row_opens(row_opens),
      .cbr_count(cbr_count), .row_seen(row_seen), .low_seen(low_seen));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // One place ends the run, for the tests and the watchdog alike.
   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Address and data are offered together and each is dropped once taken.
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!((!awvalid || awready) && (!wvalid || wready)));
      do @(posedge aclk); while (bvalid !== 1'b1);
      br = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   // One DRAM write; a full access with two-state precharge is 80 clocks.
   task automatic acc(input logic [27:0] a, input logic wd);
      @(posedge aclk);
      clr <= 1'b1;
      req_addr <= a;
      req_wide <= wd;
      req_hi <= wd;
      req_valid <= 1'b1;
      do @(posedge aclk); while (req_ready !== 1'b1);
      clr <= 1'b0;
      req_valid <= 1'b0;
      repeat (130) @(posedge aclk);
   endtask
   // Length of the next whole refresh, in clocks.
   task automatic meas(output int d);
      while (refresh_active === 1'b1) @(posedge aclk);
      while (refresh_active !== 1'b1) @(posedge aclk);
      d = 0;
      while (refresh_active === 1'b1) begin
         @(posedge aclk);
         d++;
      end
   endtask
   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge aclk);
      fails++;
      close_out();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(DARC_ADDR_AREA);
      chk("area reset", rd, 32'h0000_0000);
      axi_rd(DARC_ADDR_REFR);
      chk("refresh reset", rd, 32'h0000_0000);
      axi_rd(4'h2);
      chk("unmapped rresp", {30'h0, rr}, {30'h0, DARC_RESP_ERR});
      axi_wr(DARC_ADDR_STAT, 32'h0000_0000);
      chk("status bresp", {30'h0, br}, {30'h0, DARC_RESP_ERR});
      $display("test reset done");
      axi_wr(DARC_ADDR_AREA, 32'h0000_ff00);
      axi_rd(DARC_ADDR_AREA);
      chk("area low byte", rd, 32'h0000_ff00);
      axi_wr(DARC_ADDR_REFR, 32'h0000_00f0);
      axi_rd(DARC_ADDR_REFR);
      chk("refresh no key", rd, 32'h0000_0000);
      axi_wr(DARC_ADDR_REFR, 32'h0000_5a30);
      axi_rd(DARC_ADDR_REFR);
      chk("refresh reserved", rd, 32'h0000_0030);
      axi_wr(DARC_ADDR_REFR, 32'h0000_5a00);
      $display("test registers done");
      // Strobe scheme against bus width, order {hcas,lcas,hwe,lwe}.
      for (int i = 0; i < 4; i++) begin
         axi_wr(DARC_ADDR_AREA, i[0] ? 32'h0000_8000 : 32'h0000_0000);
         acc(28'h012_3450, !i[1]);
         chk("strobes", {28'h0, low_seen},
            i[1] ? 32'h5 : (i[0] ? 32'h7 : 32'hd));
      end
      $display("test strobes done");
      acc(28'habc_def0, 1'b1);
      chk("row plain", {4'h0, row_seen}, 32'h0abc_def0);
      for (int c = 0; c < 3; c++) begin
         axi_wr(DARC_ADDR_AREA, 32'h0000_0400 | (c << 8));
         acc(28'habc_def0, 1'b1);
         chk("row shifted", {4'h0, row_seen},
            32'h0abc_def0 >> (8 + c));
      end
      chk("ras up", {31'h0, ras_n}, 32'h1);
      $display("test mux done");
      axi_wr(DARC_ADDR_AREA, 32'h0000_5000);
      n0 = row_opens;
      acc(28'h000_1200, 1'b1);
      acc(28'h000_12fc, 1'b1);
      chk("page rows", row_opens - n0, 1);
      chk("ras down", {31'h0, ras_n}, 32'h0);
      acc(28'h000_1300, 1'b1);
      chk("new row", row_opens - n0, 2);
      axi_wr(DARC_ADDR_AREA, 32'h0000_4000);
      n0 = row_opens;
      acc(28'h000_1300, 1'b1);
      acc(28'h000_1304, 1'b1);
      chk("full rows", row_opens - n0, 2);
      axi_wr(DARC_ADDR_AREA, 32'h0000_0000);
      acc(28'h000_0000, 1'b1);
      $display("test burst done");
      // Counter runs every clock; with refresh off only the flag moves.
      repeat (300) @(posedge aclk);
      chk("no refresh", {31'h0, refresh_active}, 32'h0);
      axi_rd(DARC_ADDR_STAT);
      chk("match flag", {31'h0, rd[15]}, 32'h1);
      axi_wr(DARC_ADDR_REFR, 32'h0000_5a80);
      n0 = cbr_count;
      meas(d0);
      chk("cbr seen", cbr_count - n0, 1);
      axi_wr(DARC_ADDR_REFR, 32'h0000_5ab0);
      meas(dk);
      chk("wait off", dk, d0);
      rwe <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         axi_wr(DARC_ADDR_REFR, 32'h0000_5a80 | (k << 4));
         meas(dk);
         chk("wait states", dk - d0, (k + 1) * 20);
      end
      $display("test cbr done");
      axi_wr(DARC_ADDR_REFR, 32'h0000_5ac0);
      repeat (600) @(posedge aclk);
      chk("self refresh", {31'h0, refresh_active}, 32'h1);
      chk("self ras", {31'h0, ras_n}, 32'h0);
      axi_wr(DARC_ADDR_REFR, 32'h0000_5a80);
      repeat (200) @(posedge aclk);
      axi_wr(DARC_ADDR_REFR, 32'h0000_5a00);
      repeat (200) @(posedge aclk);
      chk("self exit", {31'h0, refresh_active}, 32'h0);
      $display("test self refresh done");
      close_out();
   end
endmodule
